//--- rtl/tsp_core.sv
/*
 * Task state segment handling: selector and flags save, I/O permission lookup,
 * interrupt redirection lookup, fault address capture.
 * Assumes a memory port that answers each read or write with i_mem_ack, and
 * i_mem_pf on a page fault. Requests arrive from core logic on the same clock.
 * Limitation: an interrupt lookup asked for while the extension is off is
 * finished at once without a memory access, so the core is never left waiting.
 */
`default_nettype none
module tsp_core
	import tsp_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic        i_virtual_mode_ext_flag,
	input  wire logic        i_io_req,
	input  wire logic [15:0] i_io_port,
	input  wire logic        i_save_req,
	input  wire logic        i_seg_is32,
	input  wire logic [15:0] i_sel_value,
	input  wire logic [31:0] i_flags_register,
	input  wire logic        i_restore_req,
	input  wire logic [31:0] i_restore_flags,
	input  wire logic        i_v86_int_req,
	input  wire logic [7:0]  i_int_vector,
	input  wire logic [31:0] i_seg_base,
	input  wire logic [31:0] i_seg_limit,
	input  wire logic [31:0] i_map_base,
	input  wire logic        i_mem_ack,
	input  wire logic        i_mem_pf,
	input  wire logic [7:0]  i_mem_rdata,
	output logic             o_mem_req,
	output logic             o_mem_we,
	output logic [31:0]      o_mem_addr,
	output logic [31:0]      o_mem_wdata,
	output logic             o_io_issue,
	output logic             o_general_protection_fault,
	output logic             o_page_fault,
	output logic [31:0]      o_fault_address_register,
	output logic [31:0]      o_restored_flags,
	output logic             o_redirect,
	output logic             o_done
);
	import tsp_pkg::*;

	// ********************
	// State
	// ********************
	typedef struct packed {
		tsp_state_e  st;
		logic        mem_req;
		logic        mem_we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [2:0]  bit_sel;
		logic        io_issue;
		logic        gpf;
		logic        pf;
		logic [31:0] far;
		logic [31:0] rflags;
		logic        redirect;
		logic        done;
	} tsp_state_s;

	tsp_state_s  r;
	tsp_state_s  next_r;
	logic        virtual_mode_ext_flag;
	logic [32:0] perm_addr;
	logic [31:0] redir_addr;

	// ********************
	// Synchroniser
	// ********************
	// Control register bit comes from another unit's timing, so it is synchronised
	tsp_sync u_vme (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_async (i_virtual_mode_ext_flag),
		.o_level (virtual_mode_ext_flag)
	);

	// ********************
	// Lookup addresses
	// ********************
	// Full 33-bit sum so the offset can never wrap at 64K or 4G
	assign perm_addr = {1'b0, i_map_base} + {20'h0_0000, i_io_port[15:TSP_BYTE_SHIFT]};
	// Redirection bitmap sits just below the I/O map, one bit per vector
	assign redir_addr = i_seg_base + i_map_base - TSP_REDIR_OFFSET
		+ {27'h000_0000, i_int_vector[7:TSP_BYTE_SHIFT]};

	// ********************
	// Next state
	// ********************
	always_comb begin
		next_r          = r;
		next_r.io_issue = 1'b0;
		next_r.gpf      = 1'b0;
		next_r.pf       = 1'b0;
		next_r.done     = 1'b0;
		next_r.redirect = 1'b0;
		unique case (r.st)
			TSP_IDLE: begin
				if (i_io_req) begin
					if (perm_addr > {1'b0, i_seg_limit}) begin
						next_r.gpf  = 1'b1;
						next_r.done = 1'b1;
					end else begin
						next_r.st      = TSP_PERM;
						next_r.mem_req = 1'b1;
						next_r.mem_we  = 1'b0;
						next_r.addr    = i_seg_base + perm_addr[31:0];
						next_r.bit_sel = i_io_port[2:0];
					end
				end else if (i_save_req) begin
					next_r.st      = TSP_SAVE;
					next_r.mem_req = 1'b1;
					next_r.mem_we  = 1'b1;
					next_r.addr    = i_seg_base;
					if (i_seg_is32) begin
						next_r.wdata = {16'h0000, i_sel_value} & TSP_SEL_UPPER_ZERO;
					end else begin
						next_r.wdata = i_flags_register & TSP_FLAGS_LOW_MASK;
					end
				end else if (i_restore_req) begin
					next_r.rflags = i_restore_flags;
					if (!i_seg_is32) begin
						// Upper word never saved, so the mode bit stays off
						next_r.rflags = i_restore_flags & TSP_FLAGS_LOW_MASK;
					end
					next_r.done = 1'b1;
				end else if (i_v86_int_req && virtual_mode_ext_flag) begin
					next_r.st      = TSP_REDIR;
					next_r.mem_req = 1'b1;
					next_r.mem_we  = 1'b0;
					next_r.addr    = redir_addr;
					next_r.bit_sel = i_int_vector[TSP_BYTE_SHIFT-1:0];
				end else if (i_v86_int_req) begin
					// Extension off: nothing to redirect, so finish without a lookup
					next_r.done = 1'b1;
				end
			end
			TSP_PERM: begin
				if (i_mem_ack) begin
					next_r.mem_req = 1'b0;
					next_r.st      = TSP_DONE;
					next_r.done    = 1'b1;
					if (i_mem_pf) begin
						next_r.pf  = 1'b1;
						next_r.far = r.addr;
					end else if (i_mem_rdata[r.bit_sel]) begin
						// Transfer released only after the permission bit reads clear
						next_r.gpf = 1'b1;
					end else begin
						next_r.io_issue = 1'b1;
					end
				end
			end
			TSP_SAVE: begin
				if (i_mem_ack) begin
					next_r.mem_req = 1'b0;
					next_r.st      = TSP_DONE;
					next_r.done    = 1'b1;
					if (i_mem_pf) begin
						next_r.pf  = 1'b1;
						next_r.far = r.addr;
					end
				end
			end
			TSP_REDIR: begin
				if (i_mem_ack) begin
					next_r.mem_req = 1'b0;
					next_r.st      = TSP_DONE;
					next_r.done    = 1'b1;
					if (i_mem_pf) begin
						next_r.pf  = 1'b1;
						next_r.far = r.addr;
					end else begin
						next_r.redirect = ~i_mem_rdata[r.bit_sel];
					end
				end
			end
			TSP_DONE: begin
				// One quiet cycle keeps a new request off the tail of the last answer
				next_r.st = TSP_IDLE;
			end
			default: begin
				next_r.st = TSP_IDLE;
			end
		endcase
	end

	// ********************
	// Registers
	// ********************
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			r <= '{st: TSP_IDLE, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// ********************
	// Outputs
	// ********************
	// Every output is a register field, so nothing combinational reaches a pin
	assign o_mem_req                  = r.mem_req;
	assign o_mem_we                   = r.mem_we;
	assign o_mem_addr                 = r.addr;
	assign o_mem_wdata                = r.wdata;
	assign o_io_issue                 = r.io_issue;
	assign o_general_protection_fault = r.gpf;
	assign o_page_fault               = r.pf;
	assign o_fault_address_register   = r.far;
	assign o_restored_flags           = r.rflags;
	assign o_redirect                 = r.redirect;
	assign o_done                     = r.done;
endmodule
`default_nettype wire

//--- rtl/tsp_pkg.sv
/*
 * Constants, types and rule summary for the task state and I/O permission block.
 * Assumes a core that drives requests one at a time and a memory port that answers them.
 */
// Contract
// - With virtual_mode_ext_flag set, redirect v86 interrupts via the segment's redirection bitmap.
// - In a 32-bit segment, each saved selector is four bytes, upper two zero.
// - A faulting segment access loads its address into fault_address_register.
// - Saving to a 16-bit segment stores only the low half of flags_register.
// - Returning to a 16-bit task never re-enters virtual-8086 mode.
// - Permission byte lives at map base plus port offset inside the segment.
// - The segment is 32-bit; lookup addresses never wrap at 64K.
// - Map base plus offset above the segment limit raises general_protection_fault.
`default_nettype none
package tsp_pkg;
	localparam logic [31:0] TSP_SEL_UPPER_ZERO = 32'h0000_FFFF;
	localparam logic [31:0] TSP_FLAGS_LOW_MASK = 32'h0000_FFFF;
	localparam int          TSP_VM_BIT         = 17;
	localparam int          TSP_BYTE_SHIFT     = 3;
	localparam logic [31:0] TSP_MAP_BOUND      = 32'h0000_DFFF;
	localparam logic [31:0] TSP_REDIR_OFFSET   = 32'h0000_0020;
	localparam logic [4:0]  TSP_ST_IDLE        = 5'h01;
	typedef enum logic [4:0] {
		TSP_IDLE  = 5'h01,
		TSP_PERM  = 5'h02,
		TSP_SAVE  = 5'h04,
		TSP_REDIR = 5'h08,
		TSP_DONE  = 5'h10
	} tsp_state_e;
endpackage
`default_nettype wire

//--- rtl/tsp_sync.sv
/*
 * Three-flop synchroniser for an outside level.
 * Assumes one clock; change taken when second and third flops agree.
 */
`default_nettype none
module tsp_sync (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_async,
	output logic      o_level
);
	logic [2:0] shreg;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			shreg   <= 3'h0;
			o_level <= 1'b0;
		end else begin
			shreg <= {shreg[1:0], i_async};
			if (shreg[1] == shreg[2]) begin
				o_level <= shreg[2];
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/tsp_checker.sv
/* Port assertions for tsp_core. Assumes bind by name. */
`default_nettype none
module tsp_checker (
	input wire logic        i_clock,
	input wire logic        i_nrst,
	input wire logic        i_mem_ack,
	input wire logic        o_mem_req,
	input wire logic        o_mem_we,
	input wire logic        o_io_issue,
	input wire logic        o_general_protection_fault,
	input wire logic        o_page_fault,
	input wire logic        o_done,
	input wire logic [31:0] o_mem_addr,
	input wire logic [31:0] o_mem_wdata,
	input wire logic [31:0] o_fault_address_register
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	chk_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
		else $error("request not held");
	chk_ack_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
		else $error("request kept after ack");
	chk_upper_zero: assert property (o_mem_req && o_mem_we |-> o_mem_wdata[31:16] == 16'h0000)
		else $error("upper half written");
	chk_deny_blocks: assert property (o_general_protection_fault |-> !o_io_issue)
		else $error("denied access issued");
	chk_issue_ack: assert property (o_io_issue |-> $past(i_mem_ack) && !o_mem_req)
		else $error("issue before lookup");
	chk_issue_done: assert property (o_io_issue |-> o_done)
		else $error("issue without done");
	chk_fault_addr: assert property (o_page_fault |-> o_fault_address_register == $past(o_mem_addr))
		else $error("wrong fault address");
	chk_done_pulse: assert property (o_done |=> !o_done)
		else $error("done too long");
endmodule
bind tsp_core tsp_checker i_tsp_checker (
	.i_clock                    (i_clock),
	.i_nrst                     (i_nrst),
	.i_mem_ack                  (i_mem_ack),
	.o_mem_req                  (o_mem_req),
	.o_mem_we                   (o_mem_we),
	.o_io_issue                 (o_io_issue),
	.o_general_protection_fault (o_general_protection_fault),
	.o_page_fault               (o_page_fault),
	.o_done                     (o_done),
	.o_mem_addr                 (o_mem_addr),
	.o_mem_wdata                (o_mem_wdata),
	.o_fault_address_register   (o_fault_address_register)
);
`default_nettype wire

//--- bench/tsp_mem_model.sv
/* Memory holding the segment. Acks i_wait cycles after the edge that first sees a request; reads return i_fill. */
`default_nettype none
module tsp_mem_model (
	input  wire logic        i_clock,
	input  wire logic        i_nrst,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic [31:0] i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic [31:0] i_pf_addr,
	input  wire logic [7:0]  i_fill,
	input  wire logic [3:0]  i_wait,
	output logic             o_ack,
	output logic             o_pf,
	output logic [7:0]       o_rdata,
	output logic [31:0]      o_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt;
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			{cnt, o_ack, o_pf, o_rdata} <= '0;
		end else begin
			{o_ack, o_pf} <= 2'h0;
			o_rdata <= ~o_rdata; // Stale data never looks valid
			if (i_req && !o_ack) begin
				cnt <= cnt + 4'h1;
				if (cnt >= i_wait) begin
					cnt <= 4'h0;
					o_ack <= 1'b1;
					o_pf <= (i_addr == i_pf_addr);
					o_rdata <= i_fill;
					if (i_we) o_wdata <= i_wdata;
				end
			end
		end
	end
endmodule
`default_nettype wire

//--- bench/task_state_io_permission_test.sv
/* Self-checking bench for tsp_core with a memory model. */
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
	$display("BAD %0t %h %h", $time, a, e); end end
module task_state_io_permission_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tsp_pkg::*;
	logic i_clock = 0, i_nrst = 0, i_virtual_mode_ext_flag = 0, i_io_req = 0, i_save_req = 0;
	logic i_seg_is32 = 0, i_restore_req = 0, i_v86_int_req = 0;
	logic [15:0] i_io_port = 0, i_sel_value = 0;
	logic [7:0] i_int_vector = 0, fill = 0, i_mem_rdata;
	logic [31:0] i_flags_register = 0, i_restore_flags = 0, i_seg_base = 32'h1000;
	logic [31:0] i_seg_limit = 32'h2_0000, i_map_base = 32'h100, pfa = '1, ma, wd;
	logic [3:0] wt = 0, seen;
	logic i_mem_ack, i_mem_pf, o_mem_req, o_mem_we, o_io_issue, o_general_protection_fault;
	logic o_page_fault, o_redirect, o_done;
	logic [31:0] o_mem_addr, o_mem_wdata, o_fault_address_register, o_restored_flags;
	int error_cnt = 0, samples_checked = 0;
	tsp_core i_tsp_core (.*);
	tsp_mem_model i_tsp_mem_model (.i_clock(i_clock), .i_nrst(i_nrst), .i_req(o_mem_req),
		.i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_pf_addr(pfa),
		.i_fill(fill), .i_wait(wt), .o_ack(i_mem_ack), .o_pf(i_mem_pf), .o_rdata(i_mem_rdata),
		.o_wdata(wd));
	initial forever #4 i_clock = ~i_clock;
	task end_of_test();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Pulses are gathered on the same edge as done, which may already stand on entry
	task automatic run();
		int n;
		{seen, ma} = '0;
		@(negedge i_clock);
		{i_io_req, i_save_req, i_restore_req, i_v86_int_req} = 4'h0;
		for (n = 0; n < 60; n++) begin
			if (o_mem_req) ma = o_mem_addr;
			seen |= {o_io_issue, o_general_protection_fault, o_page_fault, o_redirect};
			if (o_done === 1'b1) break;
			@(negedge i_clock);
		end
		if (n == 60) begin
			error_cnt++;
			end_of_test();
		end else begin
			repeat (2) @(negedge i_clock);
		end
	endtask
	task automatic t_io();
		i_map_base = 32'hFFF0; i_io_port = 16'hFFFF; fill = 8'h7F; i_io_req = 1; run();
		`CHK(ma, 32'h0001_2FEF)
		`CHK(seen, 4'h8)
		wt = 3; fill = 8'h80; i_io_req = 1; run(); // Slow memory, denying bit
		`CHK(seen, 4'h4)
		wt = 0; i_map_base = 32'h100; i_io_port = 16'h0800; i_seg_limit = 32'h1FF;
		i_io_req = 1; run();
		`CHK({seen, ma}, {4'h4, 32'h0})
		i_seg_limit = 32'h200; fill = 8'h00; i_io_req = 1; run();
		`CHK(seen, 4'h8)
		i_seg_limit = 32'h2_0000;
	endtask
	task automatic t_save();
		i_seg_is32 = 1; i_sel_value = 16'hABCD; i_save_req = 1; run();
		`CHK(wd, 32'h0000_ABCD)
		i_seg_is32 = 0; i_flags_register = 32'hFFFF_1234; i_save_req = 1; run();
		`CHK(wd, 32'h0000_1234)
		i_restore_flags = 32'h0002_0202; i_restore_req = 1; run();
		`CHK(o_restored_flags, 32'h0000_0202)
		i_seg_is32 = 1; i_restore_req = 1; run(); // 32-bit segment keeps the mode bit
		`CHK(o_restored_flags, 32'h0002_0202)
	endtask
	task automatic t_fault();
		i_io_port = 16'h0010; pfa = 32'h1102; i_io_req = 1; run();
		`CHK({seen, o_fault_address_register}, {4'h2, 32'h1102})
		i_int_vector = 8'h09; fill = 8'hFD; i_v86_int_req = 1; run(); // Extension still off
		`CHK({seen, ma}, {4'h0, 32'h0})
		i_virtual_mode_ext_flag = 1; repeat (8) @(negedge i_clock);
		i_v86_int_req = 1; run();
		`CHK({seen, ma}, {4'h1, 32'h10E1})
		fill = 8'h02; i_v86_int_req = 1; run(); // Set bit keeps the interrupt in protected mode
		`CHK({seen, ma}, {4'h0, 32'h10E1})
	endtask
	initial begin
		repeat (16) @(negedge i_clock);
		i_nrst = 1;
		t_io(); t_save(); t_fault();
		end_of_test();
	end
endmodule
`default_nettype wire
